// ---- rtl/crf_pkg.sv ----
/*
  Shared constants for the core register set: widths, register port
  offsets, flag bit positions, bank slot indices and reset values.
  Assumes a single core clock and a plain strobe register port.
*/
package crf_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned PORT_AW = 8;
  localparam int unsigned PORT_DW = 32;
  localparam int unsigned FLAG_W = 11;
  localparam int unsigned IPL_W = 3;
  localparam int unsigned BANK_SLOTS = 7;
  localparam int unsigned BANK_COUNT = 2;
  localparam int unsigned SWINT_LIMIT = 31;

  // Slots inside one bank
  localparam int unsigned SLOT_D0 = 0;
  localparam int unsigned SLOT_D1 = 1;
  localparam int unsigned SLOT_D2 = 2;
  localparam int unsigned SLOT_D3 = 3;
  localparam int unsigned SLOT_A0 = 4;
  localparam int unsigned SLOT_A1 = 5;
  localparam int unsigned SLOT_FB = 6;

  // Register port byte offsets
  localparam logic [7:0] OFS_DATA_REG_ZERO = 8'h00;
  localparam logic [7:0] OFS_DATA_REG_ONE = 8'h04;
  localparam logic [7:0] OFS_DATA_REG_TWO = 8'h08;
  localparam logic [7:0] OFS_DATA_REG_THREE = 8'h0C;
  localparam logic [7:0] OFS_ADDRESS_REG_ZERO = 8'h10;
  localparam logic [7:0] OFS_ADDRESS_REG_ONE = 8'h14;
  localparam logic [7:0] OFS_FRAME_BASE = 8'h18;
  localparam logic [7:0] OFS_STATIC_BASE = 8'h1C;
  localparam logic [7:0] OFS_VECTOR_TABLE_BASE = 8'h20;
  localparam logic [7:0] OFS_PROGRAM_COUNTER = 8'h24;
  localparam logic [7:0] OFS_USER_STACK_POINTER = 8'h28;
  localparam logic [7:0] OFS_INTERRUPT_STACK_POINTER = 8'h2C;
  localparam logic [7:0] OFS_STATUS_FLAGS = 8'h30;
  localparam logic [7:0] OFS_DATA_PAIR_LOWER = 8'h34;
  localparam logic [7:0] OFS_DATA_PAIR_UPPER = 8'h38;
  localparam logic [7:0] OFS_ADDRESS_PAIR = 8'h3C;
  localparam logic [7:0] OFS_ACTIVE_STACK = 8'h40;
  localparam logic [7:0] OFS_DATA_ZERO_HIGH_BYTE = 8'h44;
  localparam logic [7:0] OFS_DATA_ZERO_LOW_BYTE = 8'h48;
  localparam logic [7:0] OFS_DATA_ONE_HIGH_BYTE = 8'h4C;
  localparam logic [7:0] OFS_DATA_ONE_LOW_BYTE = 8'h50;

  // Flag bit positions
  localparam int unsigned FLG_CARRY = 0;
  localparam int unsigned FLG_DEBUG = 1;
  localparam int unsigned FLG_ZERO = 2;
  localparam int unsigned FLG_SIGN = 3;
  localparam int unsigned FLG_BANK = 4;
  localparam int unsigned FLG_OVERFLOW = 5;
  localparam int unsigned FLG_INT_EN = 6;
  localparam int unsigned FLG_STACK_SEL = 7;
  localparam int unsigned FLG_IPL_LO = 8;
  localparam int unsigned FLG_RESERVED = 11;

  // Operand sizes for zero and sign
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  // Reset values
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [19:0] RST_ADDR = 20'h00000;
  localparam logic [10:0] RST_FLAGS = 11'h000;

endpackage

// ---- rtl/crf_bank.sv ----
/*
  One register bank: four data slots, two address slots and the frame
  base, each 16 bits with byte enables. Assumes the caller gates the
  write enables with the bank select.
*/
`timescale 1ns/100ps
module crf_bank (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [crf_pkg::BANK_SLOTS-1:0] wr_en_i,
  input wire logic [crf_pkg::BANK_SLOTS-1:0] wr_hi_sel_i,
  input wire logic [1:0] wr_be_i,
  input wire logic [crf_pkg::DATA_W-1:0] wr_data_lo_i,
  input wire logic [crf_pkg::DATA_W-1:0] wr_data_hi_i,
  output logic [crf_pkg::BANK_SLOTS-1:0][crf_pkg::DATA_W-1:0] slots_o
);
  import crf_pkg::*;

  logic [BANK_SLOTS-1:0][DATA_W-1:0] slot_r;
  logic [BANK_SLOTS-1:0][DATA_W-1:0] slot_nxt;

  genvar g;
  generate
    for (g = 0; g < BANK_SLOTS; g++) begin : g_slot
      logic [DATA_W-1:0] src;
      always_comb begin
        src = wr_hi_sel_i[g] ? wr_data_hi_i : wr_data_lo_i;
        slot_nxt[g] = slot_r[g];
        // Unselected bank keeps its contents
        if (wr_en_i[g]) begin
          if (wr_be_i[0]) begin
            slot_nxt[g][7:0] = src[7:0];
          end
          if (wr_be_i[1]) begin
            slot_nxt[g][15:8] = src[15:8];
          end
        end
      end
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          slot_r[g] <= RST_DATA;
        end else begin
          slot_r[g] <= slot_nxt[g];
        end
      end
    end
  endgenerate

  assign slots_o = slot_r;

endmodule // crf_bank

// ---- rtl/crf_irq_gate.sv ----
/*
  Interrupt admission: a request passes when non-maskable, or when the
  enable flag is set and its level beats the current priority level.
  Assumes request inputs are synchronous to the core clock.
*/
`timescale 1ns/100ps
module crf_irq_gate (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic irq_req_i,
  input wire logic irq_maskable_i,
  input wire logic [crf_pkg::IPL_W-1:0] irq_level_i,
  input wire logic int_en_i,
  input wire logic [crf_pkg::IPL_W-1:0] ipl_i,
  output logic take_o
);
  import crf_pkg::*;

  logic take_r;
  logic take_nxt;

  always_comb begin
    take_nxt = 1'b0;
    if (irq_req_i) begin
      if (!irq_maskable_i) begin
        take_nxt = 1'b1;
      end else begin
        take_nxt = int_en_i && (irq_level_i > ipl_i);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      take_r <= 1'b0;
    end else begin
      take_r <= take_nxt;
    end
  end

  assign take_o = take_r;

endmodule // crf_irq_gate

// ---- rtl/crf_core.sv ----
/*
  Core register set with two switchable banks, program counter, vector
  base, stack pointers, static base and the status flags. Assumes a
  sequencer drives ALU results, interrupt accepts and the register port.
*/
// What this block does
// - Thirteen registers; banked seven exist twice.
// - Bank flag picks bank zero or one.
// - Sixteen-bit data; first two split bytes.
// - Data two:zero and three:one form longs.
// - Address registers sixteen bits; pair forms long.
// - Frame base sixteen bits for frame addressing.
// - Static base sixteen bits for static addressing.
// - Vector table base is twenty bits.
// - Program counter twenty bits, next instruction.
// - Two stack pointers; flag selects which.
// - Stack flag clears on interrupt accept.
// - Status flags are eleven bits wide.
// - Carry flag captures ALU carry out.
// - Zero flag set for zero result.
// - Sign flag set for negative result.
// - Overflow flag follows operation overflow.
// - Enable flag low blocks maskable interrupts.
// - Enable flag clears when interrupt accepted.
// - Priority level is three bits, 0-7.
// - Maskable interrupt needs level above current priority.
// - Reserved flag bit written zero, reads zero.
`timescale 1ns/100ps
module crf_core (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [crf_pkg::PORT_AW-1:0] reg_addr_i,
  input wire logic [crf_pkg::PORT_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [crf_pkg::PORT_DW-1:0] reg_rdata_o,
  input wire logic alu_update_i,
  input wire logic [1:0] alu_size_i,
  input wire logic [31:0] alu_result_i,
  input wire logic alu_carry_i,
  input wire logic alu_overflow_i,
  input wire logic pc_step_i,
  input wire logic [2:0] pc_step_len_i,
  input wire logic irq_req_i,
  input wire logic irq_maskable_i,
  input wire logic [crf_pkg::IPL_W-1:0] irq_level_i,
  input wire logic irq_accept_i,
  input wire logic swint_exec_i,
  input wire logic [5:0] swint_num_i,
  output logic irq_take_o,
  output logic [crf_pkg::FLAG_W-1:0] flags_o,
  output logic bank_sel_o,
  output logic [crf_pkg::DATA_W-1:0] stack_ptr_o,
  output logic [crf_pkg::DATA_W-1:0] frame_base_o,
  output logic [crf_pkg::DATA_W-1:0] static_base_o,
  output logic [crf_pkg::ADDR_W-1:0] vector_base_o,
  output logic [crf_pkg::ADDR_W-1:0] pc_o
);
  import crf_pkg::*;

  function automatic logic is_zero(input logic [1:0] size,
                                   input logic [31:0] val);
    case (size)
      SIZE_BYTE: is_zero = (val[7:0] == 8'h00);
      SIZE_WORD: is_zero = (val[15:0] == 16'h0000);
      default: is_zero = (val == 32'h0000_0000);
    endcase
  endfunction

  function automatic logic is_negative(input logic [1:0] size,
                                       input logic [31:0] val);
    case (size)
      SIZE_BYTE: is_negative = val[7];
      SIZE_WORD: is_negative = val[15];
      default: is_negative = val[31];
    endcase
  endfunction

  logic [BANK_COUNT-1:0][BANK_SLOTS-1:0][DATA_W-1:0] bank_slots;
  logic [BANK_SLOTS-1:0][DATA_W-1:0] act;
  logic [BANK_SLOTS-1:0] slot_we;
  logic [BANK_SLOTS-1:0] slot_hi;
  logic [1:0] slot_be;
  logic [DATA_W-1:0] slot_lo_data;

  logic [DATA_W-1:0] sb_r;
  logic [DATA_W-1:0] sb_nxt;
  logic [ADDR_W-1:0] vtb_r;
  logic [ADDR_W-1:0] vtb_nxt;
  logic [ADDR_W-1:0] pc_r;
  logic [ADDR_W-1:0] pc_nxt;
  logic [DATA_W-1:0] usp_r;
  logic [DATA_W-1:0] usp_nxt;
  logic [DATA_W-1:0] isp_r;
  logic [DATA_W-1:0] isp_nxt;
  logic [FLAG_W-1:0] flg_r;
  logic [FLAG_W-1:0] flg_nxt;
  logic [DATA_W-1:0] sp_view_r;
  logic [DATA_W-1:0] sp_view_nxt;
  logic [DATA_W-1:0] fb_view_r;
  logic [DATA_W-1:0] fb_view_nxt;
  logic [PORT_DW-1:0] rdata_r;
  logic [PORT_DW-1:0] rdata_nxt;

  // Two full banks, only the selected one is written
  genvar b;
  generate
    for (b = 0; b < BANK_COUNT; b++) begin : g_bank
      crf_bank u_bank (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .wr_en_i(slot_we & {BANK_SLOTS{flg_r[FLG_BANK] == 1'(b)}}),
        .wr_hi_sel_i(slot_hi),
        .wr_be_i(slot_be),
        .wr_data_lo_i(slot_lo_data),
        .wr_data_hi_i(reg_wdata_i[31:16]),
        .slots_o(bank_slots[b])
      );
    end
  endgenerate

  assign act = bank_slots[flg_r[FLG_BANK]];

  crf_irq_gate u_gate (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .irq_req_i(irq_req_i),
    .irq_maskable_i(irq_maskable_i),
    .irq_level_i(irq_level_i),
    .int_en_i(flg_r[FLG_INT_EN]),
    .ipl_i(flg_r[FLG_IPL_LO +: IPL_W]),
    .take_o(irq_take_o)
  );

  // Bank write decode
  always_comb begin
    slot_we = '0;
    slot_hi = '0;
    slot_be = 2'h3;
    slot_lo_data = reg_wdata_i[15:0];
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_DATA_REG_ZERO: slot_we[SLOT_D0] = 1'b1;
        OFS_DATA_REG_ONE: slot_we[SLOT_D1] = 1'b1;
        OFS_DATA_REG_TWO: slot_we[SLOT_D2] = 1'b1;
        OFS_DATA_REG_THREE: slot_we[SLOT_D3] = 1'b1;
        OFS_ADDRESS_REG_ZERO: slot_we[SLOT_A0] = 1'b1;
        OFS_ADDRESS_REG_ONE: slot_we[SLOT_A1] = 1'b1;
        OFS_FRAME_BASE: slot_we[SLOT_FB] = 1'b1;
        OFS_DATA_ZERO_HIGH_BYTE: begin
          slot_we[SLOT_D0] = 1'b1;
          slot_be = 2'h2;
          slot_lo_data = {reg_wdata_i[7:0], 8'h00};
        end
        OFS_DATA_ZERO_LOW_BYTE: begin
          slot_we[SLOT_D0] = 1'b1;
          slot_be = 2'h1;
        end
        OFS_DATA_ONE_HIGH_BYTE: begin
          slot_we[SLOT_D1] = 1'b1;
          slot_be = 2'h2;
          slot_lo_data = {reg_wdata_i[7:0], 8'h00};
        end
        OFS_DATA_ONE_LOW_BYTE: begin
          slot_we[SLOT_D1] = 1'b1;
          slot_be = 2'h1;
        end
        OFS_DATA_PAIR_LOWER: begin
          slot_we[SLOT_D0] = 1'b1;
          slot_we[SLOT_D2] = 1'b1;
          slot_hi[SLOT_D2] = 1'b1;
        end
        OFS_DATA_PAIR_UPPER: begin
          slot_we[SLOT_D1] = 1'b1;
          slot_we[SLOT_D3] = 1'b1;
          slot_hi[SLOT_D3] = 1'b1;
        end
        OFS_ADDRESS_PAIR: begin
          slot_we[SLOT_A0] = 1'b1;
          slot_we[SLOT_A1] = 1'b1;
          slot_hi[SLOT_A1] = 1'b1;
        end
        default: slot_we = '0;
      endcase
    end
  end

  // Unbanked registers
  always_comb begin
    sb_nxt = sb_r;
    vtb_nxt = vtb_r;
    pc_nxt = pc_r;
    usp_nxt = usp_r;
    isp_nxt = isp_r;
    if (pc_step_i) begin
      pc_nxt = pc_r + {17'h00000, pc_step_len_i};
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_STATIC_BASE: sb_nxt = reg_wdata_i[15:0];
        OFS_VECTOR_TABLE_BASE: vtb_nxt = reg_wdata_i[19:0];
        OFS_PROGRAM_COUNTER: pc_nxt = reg_wdata_i[19:0];
        OFS_USER_STACK_POINTER: usp_nxt = reg_wdata_i[15:0];
        OFS_INTERRUPT_STACK_POINTER: isp_nxt = reg_wdata_i[15:0];
        OFS_ACTIVE_STACK: begin
          if (flg_r[FLG_STACK_SEL]) begin
            usp_nxt = reg_wdata_i[15:0];
          end else begin
            isp_nxt = reg_wdata_i[15:0];
          end
        end
        default: sb_nxt = sb_r;
      endcase
    end
  end

  // Status flags; hardware clears come last and win
  always_comb begin
    flg_nxt = flg_r;
    if (reg_wr_i && (reg_addr_i == OFS_STATUS_FLAGS)) begin
      flg_nxt = reg_wdata_i[FLAG_W-1:0];
    end
    if (alu_update_i) begin
      flg_nxt[FLG_CARRY] = alu_carry_i;
      flg_nxt[FLG_ZERO] = is_zero(alu_size_i, alu_result_i);
      flg_nxt[FLG_SIGN] = is_negative(alu_size_i, alu_result_i);
      flg_nxt[FLG_OVERFLOW] = alu_overflow_i;
    end
    if (irq_accept_i) begin
      flg_nxt[FLG_INT_EN] = 1'b0;
      flg_nxt[FLG_STACK_SEL] = 1'b0;
    end
    if (swint_exec_i && (swint_num_i <= 6'(SWINT_LIMIT))) begin
      flg_nxt[FLG_STACK_SEL] = 1'b0;
    end
  end

  // Stack view registered from next values, frame base view from current slot
  always_comb begin
    sp_view_nxt = flg_nxt[FLG_STACK_SEL] ? usp_nxt : isp_nxt;
    fb_view_nxt = act[SLOT_FB];
  end

  // Read port, data valid the cycle after the strobe
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_DATA_REG_ZERO: rdata_nxt = {16'h0000, act[SLOT_D0]};
        OFS_DATA_REG_ONE: rdata_nxt = {16'h0000, act[SLOT_D1]};
        OFS_DATA_REG_TWO: rdata_nxt = {16'h0000, act[SLOT_D2]};
        OFS_DATA_REG_THREE: rdata_nxt = {16'h0000, act[SLOT_D3]};
        OFS_ADDRESS_REG_ZERO: rdata_nxt = {16'h0000, act[SLOT_A0]};
        OFS_ADDRESS_REG_ONE: rdata_nxt = {16'h0000, act[SLOT_A1]};
        OFS_FRAME_BASE: rdata_nxt = {16'h0000, act[SLOT_FB]};
        OFS_STATIC_BASE: rdata_nxt = {16'h0000, sb_r};
        OFS_VECTOR_TABLE_BASE: rdata_nxt = {12'h000, vtb_r};
        OFS_PROGRAM_COUNTER: rdata_nxt = {12'h000, pc_r};
        OFS_USER_STACK_POINTER: rdata_nxt = {16'h0000, usp_r};
        OFS_INTERRUPT_STACK_POINTER: rdata_nxt = {16'h0000, isp_r};
        OFS_ACTIVE_STACK: rdata_nxt = {16'h0000, sp_view_r};
        OFS_STATUS_FLAGS: rdata_nxt = {21'h000000, flg_r};
        OFS_DATA_PAIR_LOWER: rdata_nxt = {act[SLOT_D2], act[SLOT_D0]};
        OFS_DATA_PAIR_UPPER: rdata_nxt = {act[SLOT_D3], act[SLOT_D1]};
        OFS_ADDRESS_PAIR: rdata_nxt = {act[SLOT_A1], act[SLOT_A0]};
        OFS_DATA_ZERO_HIGH_BYTE: rdata_nxt = {24'h000000, act[SLOT_D0][15:8]};
        OFS_DATA_ZERO_LOW_BYTE: rdata_nxt = {24'h000000, act[SLOT_D0][7:0]};
        OFS_DATA_ONE_HIGH_BYTE: rdata_nxt = {24'h000000, act[SLOT_D1][15:8]};
        OFS_DATA_ONE_LOW_BYTE: rdata_nxt = {24'h000000, act[SLOT_D1][7:0]};
        default: rdata_nxt = '0;
      endcase
    end
  end

  // Unbanked register storage
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sb_r <= RST_DATA;
      vtb_r <= RST_ADDR;
      pc_r <= RST_ADDR;
      usp_r <= RST_DATA;
      isp_r <= RST_DATA;
    end else begin
      sb_r <= sb_nxt;
      vtb_r <= vtb_nxt;
      pc_r <= pc_nxt;
      usp_r <= usp_nxt;
      isp_r <= isp_nxt;
    end
  end

  // Flag storage
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flg_r <= RST_FLAGS;
    end else begin
      flg_r <= flg_nxt;
    end
  end

  // Output view storage
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sp_view_r <= RST_DATA;
      fb_view_r <= RST_DATA;
    end else begin
      sp_view_r <= sp_view_nxt;
      fb_view_r <= fb_view_nxt;
    end
  end

  // Read data storage
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign flags_o = flg_r;
  assign bank_sel_o = flg_r[FLG_BANK];
  assign stack_ptr_o = sp_view_r;
  assign frame_base_o = fb_view_r;
  assign static_base_o = sb_r;
  assign vector_base_o = vtb_r;
  assign pc_o = pc_r;

endmodule // crf_core

// ---- test/crf_core_checker.sv ----
/*
  Checker for the core register set: port reads, ALU flags, interrupt
  gate and flag clears. Assumes one core clock and active-low reset.
*/
`timescale 1ns/100ps
module crf_core_checker (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [crf_pkg::PORT_AW-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [crf_pkg::PORT_DW-1:0] reg_wdata_i,
  input wire logic [crf_pkg::PORT_DW-1:0] reg_rdata_o,
  input wire logic alu_update_i,
  input wire logic [1:0] alu_size_i,
  input wire logic [31:0] alu_result_i,
  input wire logic alu_carry_i,
  input wire logic alu_overflow_i,
  input wire logic irq_req_i,
  input wire logic irq_maskable_i,
  input wire logic [crf_pkg::IPL_W-1:0] irq_level_i,
  input wire logic irq_accept_i,
  input wire logic swint_exec_i,
  input wire logic [5:0] swint_num_i,
  input wire logic irq_take_o,
  input wire logic [crf_pkg::FLAG_W-1:0] flags_o,
  input wire logic bank_sel_o
);
  import crf_pkg::*;
  logic [31:0] mask;
  logic z_exp;
  logic s_exp;
  logic lvl_ok;
  logic bank_exp;
  always_comb begin
    mask = (alu_size_i == SIZE_BYTE) ? 32'h0000_00FF :
      (alu_size_i == SIZE_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    z_exp = ((alu_result_i & mask) == 32'h0);
    s_exp = |(alu_result_i & mask & ~(mask >> 1));
    lvl_ok = flags_o[FLG_INT_EN] && (irq_level_i > flags_o[10:8]);
    bank_exp = (reg_wr_i && reg_addr_i == OFS_STATUS_FLAGS) ?
      reg_wdata_i[FLG_BANK] : flags_o[FLG_BANK];
  end
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_mask_req;
    irq_req_i && irq_maskable_i;
  endsequence
  sequence s_sw_low;
    swint_exec_i && (swint_num_i <= 6'd31);
  endsequence
  AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero outside read cycle");
  AST_FLAG_READ: assert property (reg_rd_i && reg_addr_i == OFS_STATUS_FLAGS
    |=> reg_rdata_o == {21'h0, $past(flags_o)})
    else $error("flag read mismatch");
  AST_IRQ_MASK: assert property (s_mask_req ##0 !flags_o[FLG_INT_EN]
    |=> !irq_take_o)
    else $error("masked request taken");
  AST_IRQ_LEVEL: assert property (s_mask_req |=> irq_take_o == $past(lvl_ok))
    else $error("priority compare wrong");
  AST_I_CLR: assert property (irq_accept_i |=> !flags_o[FLG_INT_EN])
    else $error("enable flag not cleared");
  AST_U_HW: assert property (irq_accept_i |=> !flags_o[FLG_STACK_SEL])
    else $error("stack flag not cleared by accept");
  AST_U_SW: assert property (s_sw_low |=> !flags_o[FLG_STACK_SEL])
    else $error("stack flag not cleared by soft interrupt");
  AST_ZERO: assert property (alu_update_i |=> flags_o[FLG_ZERO] == $past(z_exp))
    else $error("zero flag wrong");
  AST_SIGN: assert property (alu_update_i |=> flags_o[FLG_SIGN] == $past(s_exp))
    else $error("sign flag wrong");
  AST_CARRY: assert property (alu_update_i |=> flags_o[FLG_CARRY] ==
    $past(alu_carry_i) && flags_o[FLG_OVERFLOW] == $past(alu_overflow_i))
    else $error("carry or overflow flag wrong");
  AST_BANK: assert property (bank_sel_o == $past(bank_exp))
    else $error("bank select does not follow flag write");
endmodule // crf_core_checker

bind crf_core crf_core_checker u_chk (.*);

// ---- test/crf_core_tb_top.sv ----
/*
  Testbench for the core register set: register port tasks, bank,
  stack, ALU flag and interrupt scenarios. Assumes crf_pkg offsets.
*/
`timescale 1ns/100ps
module crf_core_tb_top;
  import crf_pkg::*;
  logic clock_i, rst_b_i, reg_wr_i, reg_rd_i, alu_update_i, alu_carry_i;
  logic alu_overflow_i, pc_step_i, irq_req_i, irq_maskable_i, irq_accept_i;
  logic swint_exec_i, irq_take_o, bank_sel_o;
  logic [PORT_AW-1:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, alu_result_i;
  logic [1:0] alu_size_i;
  logic [2:0] pc_step_len_i, irq_level_i;
  logic [5:0] swint_num_i;
  logic [10:0] flags_o;
  logic [15:0] stack_ptr_o, frame_base_o, static_base_o;
  logic [19:0] vector_base_o, pc_o;
  logic [31:0] keep [0:11];
  int bad_count;
  int check_count;

  crf_core DUT (.*);

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  task automatic irq(input logic m, input logic [2:0] lv, input logic exp);
    @(posedge clock_i);
    irq_req_i <= 1'b1;
    irq_maskable_i <= m;
    irq_level_i <= lv;
    @(posedge clock_i);
    irq_req_i <= 1'b0;
    #1;
    chk({31'h0, irq_take_o}, {31'h0, exp});
  endtask

  task automatic clr(input logic hw, input logic [5:0] n);
    @(posedge clock_i);
    irq_accept_i <= hw;
    swint_exec_i <= !hw;
    swint_num_i <= n;
    @(posedge clock_i);
    irq_accept_i <= 1'b0;
    swint_exec_i <= 1'b0;
    #1;
  endtask

  task automatic alu(input logic [1:0] sz, input logic [31:0] r,
      input logic c, input logic o);
    logic [31:0] m;
    m = (sz == SIZE_BYTE) ? 32'hFF : (sz == SIZE_WORD) ? 32'hFFFF : '1;
    @(posedge clock_i);
    alu_update_i <= 1'b1;
    alu_size_i <= sz;
    alu_result_i <= r;
    alu_carry_i <= c;
    alu_overflow_i <= o;
    @(posedge clock_i);
    alu_update_i <= 1'b0;
    #1;
    chk({flags_o[5], flags_o[3:2], flags_o[0]},
      {o, |(r & m & ~(m >> 1)), (r & m) == 32'h0, c});
  endtask

  initial begin
    #20000;
    bad_count++;
    end_sim();
  end

  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, alu_update_i, alu_carry_i} = '0;
    {alu_overflow_i, pc_step_i, irq_req_i, irq_maskable_i} = '0;
    {irq_accept_i, swint_exec_i, reg_addr_i, reg_wdata_i} = '0;
    {alu_result_i, alu_size_i, pc_step_len_i, irq_level_i, swint_num_i} = '0;
    bad_count = 0;
    check_count = 0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(OFS_STATUS_FLAGS, 32'h0);
    for (int i = 0; i < 12; i++) begin
      keep[i] = 32'hF5A5_0000 + i * 32'h0001_1357;
      wr(8'(i * 4), keep[i]);
      keep[i] &= (i == 8 || i == 9) ? 32'hF_FFFF : 32'hFFFF;
    end
    for (int i = 0; i < 12; i++) begin
      rd(8'(i * 4), keep[i]);
    end
    chk({16'h0, frame_base_o}, keep[6]);
    chk({16'h0, static_base_o}, keep[7]);
    chk({12'h0, vector_base_o}, keep[8]);
    chk({12'h0, pc_o}, keep[9]);
    @(posedge clock_i);
    pc_step_i <= 1'b1;
    pc_step_len_i <= 3'd5;
    @(posedge clock_i);
    pc_step_i <= 1'b0;
    #1;
    chk({12'h0, pc_o}, keep[9] + 32'd5);
    rd(OFS_DATA_PAIR_LOWER, {keep[2][15:0], keep[0][15:0]});
    rd(OFS_DATA_PAIR_UPPER, {keep[3][15:0], keep[1][15:0]});
    rd(OFS_ADDRESS_PAIR, {keep[5][15:0], keep[4][15:0]});
    rd(OFS_DATA_ZERO_HIGH_BYTE, {24'h0, keep[0][15:8]});
    rd(OFS_DATA_ONE_LOW_BYTE, {24'h0, keep[1][7:0]});
    wr(OFS_DATA_ZERO_LOW_BYTE, 32'h0000_0177);
    keep[0][7:0] = 8'h77;
    rd(OFS_DATA_REG_ZERO, keep[0]);
    wr(OFS_ADDRESS_PAIR, 32'h1A2B_3C4D);
    rd(OFS_ADDRESS_REG_ONE, 32'h1A2B);
    rd(OFS_ADDRESS_REG_ZERO, 32'h3C4D);
    wr(OFS_DATA_PAIR_UPPER, 32'h1357_2468);
    rd(OFS_DATA_REG_THREE, 32'h1357);
    wr(OFS_DATA_ONE_HIGH_BYTE, 32'h0000_00C3);
    rd(OFS_DATA_REG_ONE, 32'hC368);
    wr(OFS_DATA_ZERO_HIGH_BYTE, 32'h0000_00A5);
    keep[0][15:8] = 8'hA5;
    rd(OFS_DATA_REG_ZERO, keep[0]);
    rd(8'h54, 32'h0);
    // Bank one holds its own copy
    wr(OFS_STATUS_FLAGS, 32'h010);
    chk({31'h0, bank_sel_o}, 32'h1);
    wr(OFS_DATA_REG_ZERO, 32'h5555);
    wr(OFS_FRAME_BASE, 32'h6666);
    rd(OFS_DATA_REG_ZERO, 32'h5555);
    chk({16'h0, frame_base_o}, 32'h6666);
    wr(OFS_STATUS_FLAGS, 32'h000);
    rd(OFS_DATA_REG_ZERO, keep[0]);
    rd(OFS_FRAME_BASE, keep[6]);
    // Stack pointer select
    wr(OFS_STATUS_FLAGS, 32'h080);
    chk({16'h0, stack_ptr_o}, keep[10]);
    rd(OFS_ACTIVE_STACK, keep[10]);
    wr(OFS_STATUS_FLAGS, 32'h000);
    chk({16'h0, stack_ptr_o}, keep[11]);
    alu(SIZE_BYTE, 32'h0000_1200, 1'b1, 1'b0);
    alu(SIZE_WORD, 32'h0001_8000, 1'b0, 1'b1);
    alu(SIZE_LONG, 32'h0000_0000, 1'b1, 1'b1);
    alu(SIZE_LONG, 32'h8000_0001, 1'b0, 1'b0);
    // Interrupts: enable set, priority two, user stack
    wr(OFS_STATUS_FLAGS, 32'h2C0);
    for (int lv = 0; lv < 8; lv++) begin
      irq(1'b1, 3'(lv), lv > 2);
    end
    clr(1'b1, 6'd0);
    chk({30'h0, flags_o[7:6]}, 32'h0);
    irq(1'b1, 3'd7, 1'b0);
    irq(1'b0, 3'd0, 1'b1);
    wr(OFS_STATUS_FLAGS, 32'h080);
    clr(1'b0, 6'd32);
    chk({31'h0, flags_o[7]}, 32'h1);
    clr(1'b0, 6'd31);
    chk({31'h0, flags_o[7]}, 32'h0);
    wr(OFS_STATUS_FLAGS, 32'h0000_077D);
    rd(OFS_STATUS_FLAGS, 32'h0000_077D);
    end_sim();
  end
endmodule // crf_core_tb_top
